// File: verilog/flash_map_pkg.sv
// constants for the code flash address map
package flash_map_pkg;
    localparam int ADDR_W = 25;
    localparam int MAX_CODE_SYS = 2;
    localparam logic [ADDR_W-1:0] CODE_16MB = 25'h100_0000;
    localparam logic [ADDR_W-1:0] CODE_8MB = 25'h080_0000;
    localparam logic [ADDR_W-1:0] CODE_6MB = 25'h060_0000;
    // layout field codes; anything but the split code selects contiguous
    localparam logic [1:0] LAYOUT_SPLIT = 2'h0;
    localparam logic [1:0] LAYOUT_RESET = 2'h3;
    localparam logic [1:0] SWAP_RESET = 2'h0;
    // system index used by security core data flash reads
    localparam logic [1:0] SYS_SECURE = 2'h2;
    // cycles after reset release before the option straps are taken
    localparam int SETTLE_CYCLES = 3;
    localparam logic [1:0] SETTLE_LAST = 2'(SETTLE_CYCLES - 1);
endpackage

// File: verilog/read_overlay_unit.sv
// window remap of read addresses for the contiguous layout
`timescale 1ns/1ps
`default_nettype none
module read_overlay_unit
    import flash_map_pkg::*;
(
    input wire logic enable_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [ADDR_W-1:0] src_base_i,
    input wire logic [ADDR_W-1:0] dst_base_i,
    input wire logic [ADDR_W-1:0] win_mask_i,
    input wire logic [ADDR_W-1:0] limit_i,
    output logic hit_o,
    output logic [ADDR_W-1:0] addr_o
);
    logic [ADDR_W-1:0] target;

    always_comb begin
        target = (dst_base_i & ~win_mask_i) | (addr_i & win_mask_i);
        // a target at or above limit_i is never taken
        hit_o = enable_i && ((addr_i & ~win_mask_i) == (src_base_i & ~win_mask_i))
            && (target < limit_i);
        addr_o = hit_o ? target : addr_i;
    end
endmodule
`default_nettype wire

// File: verilog/flash_bank_map_select.sv
// code flash layout selection, bank swap and read address map
`timescale 1ns/1ps
`default_nettype none
module flash_bank_map_select
    import flash_map_pkg::*;
#(
    parameter logic [ADDR_W-1:0] CODE_BYTES = CODE_16MB
) (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic [1:0] layout_option_byte_i,
    input wire logic [MAX_CODE_SYS-1:0] swap_option_byte_i,
    input wire logic rd_req_i,
    input wire logic rd_dflash_i,
    input wire logic [ADDR_W-1:0] rd_addr_i,
    output logic rd_ready_o,
    output logic rd_valid_o,
    output logic rd_err_o,
    output logic rd_overlay_o,
    output logic [1:0] rd_sys_o,
    output logic rd_bank_o,
    output logic [ADDR_W-1:0] rd_phys_o,
    input wire logic ovl_enable_i,
    input wire logic [ADDR_W-1:0] ovl_src_base_i,
    input wire logic [ADDR_W-1:0] ovl_dst_base_i,
    input wire logic [ADDR_W-1:0] ovl_win_mask_i,
    input wire logic [MAX_CODE_SYS-1:0] pe_busy_i,
    input wire logic [MAX_CODE_SYS-1:0] pe_bank_i,
    output logic [MAX_CODE_SYS-1:0] pe_allow_o,
    output logic map_ready_o,
    output logic split_mode_o,
    output logic [MAX_CODE_SYS-1:0] bank_swap_select_o
);
    // ********************************
    // variant geometry
    // ********************************
    localparam int NSYS = (CODE_BYTES == CODE_16MB) ? 2 : 1;
    localparam bit SPLIT_OK = (CODE_BYTES != CODE_6MB);
    localparam logic [ADDR_W-1:0] USE_BYTES = CODE_BYTES >> 1;
    localparam logic [ADDR_W-1:0] SYS_BYTES = (NSYS == 2) ? (CODE_BYTES >> 1) : CODE_BYTES;
    localparam logic [ADDR_W-1:0] BANK_BYTES = SYS_BYTES >> 1;

    if (CODE_BYTES != CODE_16MB && CODE_BYTES != CODE_8MB && CODE_BYTES != CODE_6MB) begin : g_bad
        $error("code flash size must be 16, 8 or 6 MB");
    end

    // ********************************
    // option strap capture
    // ********************************
    logic [1:0] layout_meta;
    logic [1:0] layout_sync;
    logic [MAX_CODE_SYS-1:0] swap_meta;
    logic [MAX_CODE_SYS-1:0] swap_sync;
    logic [1:0] settle;
    logic map_ready;
    logic split_mode;
    logic [MAX_CODE_SYS-1:0] valid_bank;

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            layout_meta <= LAYOUT_RESET;
            layout_sync <= LAYOUT_RESET;
            swap_meta <= SWAP_RESET;
            swap_sync <= SWAP_RESET;
        end else begin
            layout_meta <= layout_option_byte_i;
            layout_sync <= layout_meta;
            swap_meta <= swap_option_byte_i;
            swap_sync <= swap_meta;
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            settle <= 2'h0;
        end else if (settle != SETTLE_LAST) begin
            settle <= settle + 2'h1;
        end
    end

    // taken once after release, then frozen until the next reset
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            map_ready <= 1'b0;
            split_mode <= 1'b0;
            valid_bank <= SWAP_RESET;
        end else if (!map_ready && settle == SETTLE_LAST) begin
            map_ready <= 1'b1;
            split_mode <= SPLIT_OK && (layout_sync == LAYOUT_SPLIT);
            valid_bank <= swap_sync;
        end
    end

    assign map_ready_o = map_ready;
    assign split_mode_o = split_mode;
    assign bank_swap_select_o = valid_bank;

    // ********************************
    // read address decode
    // ********************************
    logic ovl_hit;
    logic [ADDR_W-1:0] ovl_addr;
    logic in_code;
    logic inv_area;
    logic [ADDR_W-1:0] off;
    logic sys;
    logic bank;
    logic [ADDR_W-1:0] phys;
    logic conflict;

    read_overlay_unit u_overlay (
        .enable_i(ovl_enable_i && !split_mode),
        .addr_i(rd_addr_i),
        .src_base_i(ovl_src_base_i),
        .dst_base_i(ovl_dst_base_i),
        .win_mask_i(ovl_win_mask_i),
        .limit_i(CODE_BYTES),
        .hit_o(ovl_hit),
        .addr_o(ovl_addr)
    );

    always_comb begin
        in_code = rd_addr_i < CODE_BYTES;
        inv_area = 1'b0;
        off = '0;
        sys = 1'b0;
        bank = 1'b0;
        phys = rd_addr_i;
        if (split_mode) begin
            // valid banks sit low, invalid banks follow at USE_BYTES
            inv_area = rd_addr_i >= USE_BYTES;
            off = inv_area ? rd_addr_i - USE_BYTES : rd_addr_i;
            sys = (NSYS == 2) && (off >= BANK_BYTES);
            if (sys) begin
                off = off - BANK_BYTES;
            end
            bank = valid_bank[sys] ^ inv_area;
            phys = (sys ? SYS_BYTES : '0) + (bank ? BANK_BYTES : '0) + off;
        end else begin
            phys = ovl_addr;
            sys = (NSYS == 2) && (phys >= SYS_BYTES);
            off = sys ? phys - SYS_BYTES : phys;
            bank = off >= BANK_BYTES;
        end
        // once map_ready is set, only a code read into the bank under programming waits
        conflict = !rd_dflash_i && pe_busy_i[sys] && (pe_bank_i[sys] == bank);
    end

    assign rd_ready_o = map_ready && !conflict;

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rd_valid_o <= 1'b0;
            rd_err_o <= 1'b0;
            rd_overlay_o <= 1'b0;
            rd_sys_o <= 2'h0;
            rd_bank_o <= 1'b0;
            rd_phys_o <= '0;
        end else begin
            rd_valid_o <= rd_req_i && rd_ready_o;
            if (rd_req_i && rd_ready_o) begin
                if (rd_dflash_i) begin
                    rd_sys_o <= SYS_SECURE;
                    rd_bank_o <= 1'b0;
                    rd_phys_o <= rd_addr_i;
                    rd_err_o <= 1'b0;
                    rd_overlay_o <= 1'b0;
                end else begin
                    rd_sys_o <= {1'b0, sys};
                    rd_bank_o <= bank;
                    rd_phys_o <= phys;
                    rd_err_o <= !in_code;
                    rd_overlay_o <= ovl_hit && !split_mode;
                end
            end
        end
    end

    // ********************************
    // programming engine permission
    // ********************************
    for (genvar s = 0; s < MAX_CODE_SYS; s++) begin : g_allow
        // split layout: only the invalid bank may be rewritten
        assign pe_allow_o[s] = map_ready && (s < NSYS)
            && (!split_mode || pe_bank_i[s] != valid_bank[s]);
    end

    // ********************************
    // assertions
    // ********************************
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    sequence s_take;
        rd_req_i && rd_ready_o && !rd_dflash_i;
    endsequence

    sequence s_split_valid_take;
        s_take ##0 split_mode && (rd_addr_i < USE_BYTES);
    endsequence

    sequence s_split_valid_ask;
        rd_req_i && !rd_dflash_i && map_ready && split_mode && (rd_addr_i < USE_BYTES);
    endsequence

    sequence s_split_invalid_take;
        s_take ##0 split_mode && (rd_addr_i >= USE_BYTES) && (rd_addr_i < CODE_BYTES);
    endsequence

    property p_layout_hold;
        map_ready ##1 map_ready |-> $stable(split_mode);
    endproperty
    a_layout_hold: assert property (p_layout_hold) else $error("layout changed");

    property p_swap_hold;
        map_ready ##1 map_ready |-> $stable(valid_bank);
    endproperty
    a_swap_hold: assert property (p_swap_hold) else $error("swap changed");

    property p_ready_soon;
        !map_ready |-> ##[1:3] map_ready;
    endproperty
    a_ready_soon: assert property (p_ready_soon) else $error("map never ready");

    property p_valid_fixed;
        s_split_valid_take |=> rd_valid_o && !rd_err_o && rd_bank_o == valid_bank[rd_sys_o[0]];
    endproperty
    a_valid_fixed: assert property (p_valid_fixed) else $error("valid range not on valid bank");

    property p_invalid_other;
        s_split_invalid_take |=> rd_valid_o && rd_bank_o != valid_bank[rd_sys_o[0]];
    endproperty
    a_invalid_other: assert property (p_invalid_other) else $error("invalid range hit valid bank");

    property p_range;
        s_take |=> rd_err_o == ($past(rd_addr_i) >= CODE_BYTES);
    endproperty
    a_range: assert property (p_range) else $error("range error wrong");

    property p_split_range;
        s_take ##0 split_mode && (rd_addr_i < CODE_BYTES) |=> rd_phys_o < CODE_BYTES;
    endproperty
    a_split_range: assert property (p_split_range) else $error("split phys out of range");

    property p_no_conflict;
        rd_valid_o && rd_sys_o != SYS_SECURE |->
            !($past(pe_busy_i[sys]) && $past(pe_bank_i[sys]) == rd_bank_o);
    endproperty
    a_no_conflict: assert property (p_no_conflict) else $error("read of bank in programming");

    property p_secure_sys;
        rd_req_i && rd_ready_o && rd_dflash_i |=> rd_valid_o && rd_sys_o == SYS_SECURE;
    endproperty
    a_secure_sys: assert property (p_secure_sys) else $error("data flash not on third system");

    property p_sys_count;
        rd_valid_o && rd_sys_o != SYS_SECURE |-> rd_sys_o < 2'(NSYS);
    endproperty
    a_sys_count: assert property (p_sys_count) else $error("absent system addressed");

    property p_overlay_contig;
        rd_valid_o && rd_overlay_o |-> !split_mode;
    endproperty
    a_overlay_contig: assert property (p_overlay_contig) else $error("overlay in split layout");

    property p_exec_while_prog;
        s_split_valid_ask ##0 pe_busy_i[sys] && pe_bank_i[sys] != valid_bank[sys] |-> rd_ready_o;
    endproperty
    a_exec_while_prog: assert property (p_exec_while_prog) else $error("valid read stalled");
endmodule
`default_nettype wire

// File: bench/code_fetch_master.sv
// bus master model that fetches code through the flash map
`timescale 1ns/1ps
`default_nettype none
module code_fetch_master
    import flash_map_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rd_ready_i,
    output logic rd_req_o,
    output logic rd_dflash_o,
    output logic [ADDR_W-1:0] rd_addr_o
);
    initial begin
        rd_req_o = 1'b0;
        rd_dflash_o = 1'b0;
        rd_addr_o = '0;
    end
    // request held until taken or bound runs out; ok tells which
    task automatic fetch(input logic [ADDR_W-1:0] a, input logic d, output logic ok);
        int n;
        ok = 1'b0;
        @(negedge core_clk_i);
        rd_req_o = 1'b1;
        rd_dflash_o = d;
        rd_addr_o = a;
        for (n = 0; n < 20 && !ok; n++) begin
            #1;
            if (rd_ready_i === 1'b1) begin
                ok = 1'b1;
            end
            @(negedge core_clk_i);
        end
        // released lines show the inverse of the last value
        rd_req_o = 1'b0;
        rd_dflash_o = ~d;
        rd_addr_o = ~a;
    endtask
endmodule
`default_nettype wire

// File: bench/flash_bank_map_select_tb_top.sv
// self-checking bench for the code flash map select
`timescale 1ns/1ps
`default_nettype none
module flash_bank_map_select_tb_top;
    import flash_map_pkg::*;
    logic core_clk_i, reset_i, rd_req_i, rd_dflash_i, rd_ready_o, rd_valid_o, rd_err_o;
    logic rd_overlay_o, rd_bank_o, ovl_enable_i, map_ready_o, split_mode_o;
    logic [1:0] layout_option_byte_i, swap_option_byte_i, rd_sys_o, pe_busy_i, pe_bank_i;
    logic [1:0] pe_allow_o, bank_swap_select_o, sw_cap;
    logic [ADDR_W-1:0] rd_addr_i, rd_phys_o, ovl_src_base_i, ovl_dst_base_i, ovl_win_mask_i;
    logic sp;
    logic [31:0] r = 32'd78609;
    int n_mismatch = 0;
    int checks = 0;
    flash_bank_map_select flash_bank_map_select_inst (.core_clk_i(core_clk_i),
        .reset_i(reset_i), .layout_option_byte_i(layout_option_byte_i),
        .swap_option_byte_i(swap_option_byte_i), .rd_req_i(rd_req_i),
        .rd_dflash_i(rd_dflash_i), .rd_addr_i(rd_addr_i), .rd_ready_o(rd_ready_o),
        .rd_valid_o(rd_valid_o), .rd_err_o(rd_err_o), .rd_overlay_o(rd_overlay_o),
        .rd_sys_o(rd_sys_o), .rd_bank_o(rd_bank_o), .rd_phys_o(rd_phys_o),
        .ovl_enable_i(ovl_enable_i), .ovl_src_base_i(ovl_src_base_i),
        .ovl_dst_base_i(ovl_dst_base_i), .ovl_win_mask_i(ovl_win_mask_i),
        .pe_busy_i(pe_busy_i), .pe_bank_i(pe_bank_i), .pe_allow_o(pe_allow_o),
        .map_ready_o(map_ready_o), .split_mode_o(split_mode_o),
        .bank_swap_select_o(bank_swap_select_o));
    code_fetch_master code_fetch_master_inst (.core_clk_i(core_clk_i),
        .rd_ready_i(rd_ready_o), .rd_req_o(rd_req_i), .rd_dflash_o(rd_dflash_i),
        .rd_addr_o(rd_addr_i));
    initial begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        if (n_mismatch == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic do_reset(input logic [1:0] lay, input logic [1:0] sw);
        @(negedge core_clk_i);
        reset_i = 1'b1;
        layout_option_byte_i = lay;
        swap_option_byte_i = sw;
        repeat (3) @(negedge core_clk_i);
        chk({map_ready_o, pe_allow_o}, 0);
        reset_i = 1'b0;
        @(negedge core_clk_i);
        chk(map_ready_o, 0);
        @(negedge core_clk_i);
        chk(map_ready_o, 0);
        @(negedge core_clk_i);
        chk(map_ready_o, 1);
        sp = (lay == LAYOUT_SPLIT);
        sw_cap = sw;
        layout_option_byte_i = ~lay;
        swap_option_byte_i = ~sw;
        repeat (4) @(negedge core_clk_i);
        chk(split_mode_o, sp);
        if (sp) chk(bank_swap_select_o, sw);
    endtask
    // one read with random programming load, checked against the model
    task automatic rd(input logic [ADDR_W-1:0] a, input logic d);
        int ph, sy, bk;
        logic er, ok, ov;
        er = !d && a >= 25'h100_0000;
        r = lfsr(r);
        pe_busy_i = er ? 2'h0 : r[1:0];
        pe_bank_i = r[3:2];
        ovl_enable_i = r[4];
        ovl_src_base_i = r[5] ? a : r[24:0];
        // window of 64KB redirected to 4MB; never in split layout or for data flash
        ov = !sp && !d && r[4] && (a / 32'h1_0000 == ovl_src_base_i / 32'h1_0000);
        sy = (a % 32'h80_0000) / 32'h40_0000;
        bk = sw_cap[sy] ^ (a >= 32'h80_0000);
        ph = sy * 32'h80_0000 + bk * 32'h40_0000 + a % 32'h40_0000;
        if (!sp) begin
            ph = ov ? 32'h40_0000 + a % 32'h1_0000 : a;
            sy = ph >= 32'h80_0000;
            bk = (ph % 32'h80_0000) >= 32'h40_0000;
        end
        #1;
        chk(pe_allow_o, sp ? pe_bank_i ^ sw_cap : 2'h3);
        code_fetch_master_inst.fetch(a, d, ok);
        chk(ok, d || !(pe_busy_i[sy] && pe_bank_i[sy] == bk));
        if (ok) begin
            chk(rd_valid_o, 1);
            chk({rd_err_o, rd_overlay_o}, {er, ov});
            if (d) chk(rd_sys_o, SYS_SECURE);
            if (!d && !er) chk({rd_sys_o, rd_bank_o, rd_phys_o}, {sy[1:0], bk[0], ph[24:0]});
            @(negedge core_clk_i);
            chk(rd_valid_o, 0);
        end
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        reset_i = 1'b1;
        {ovl_enable_i, pe_busy_i, pe_bank_i} = '0;
        {layout_option_byte_i, swap_option_byte_i} = '0;
        {ovl_src_base_i, ovl_dst_base_i, ovl_win_mask_i} = '0;
        ovl_win_mask_i = 25'h000_ffff;
        ovl_dst_base_i = 25'h040_0000;
        for (int m = 0; m < 7; m++) begin
            r = lfsr(r);
            do_reset(m < 4 ? LAYOUT_SPLIT : 2'(m - 3), 2'(m));
            for (int k = 0; k < 25; k++) begin
                r = lfsr(r);
                rd({r[28] & r[27], r[23:0]}, k % 6 == 5);
            end
        end
        finish_test();
    end
endmodule
`default_nettype wire
